// file: hdl/gtmss_pkg.sv
// Constants shared by the pin-mapping and spur-setting block
package gtmss_pkg;
    // Register offsets on the configuration port
    localparam logic [7:0] GTMSS_OFS_PIN5_FUNC = 8'hE5;
    localparam logic [7:0] GTMSS_OFS_PIN6_FUNC = 8'hE6;
    localparam logic [7:0] GTMSS_OFS_SPUR = 8'hF7;
    // Values after reset
    localparam logic [7:0] GTMSS_RST_PIN_FUNC = 8'h00;
    localparam logic [7:0] GTMSS_RST_SPUR = 8'h00;
    // Field positions inside a pin function register
    localparam int GTMSS_IDX_MSB = 6;
    localparam int GTMSS_IDX_LSB = 0;
    localparam int GTMSS_ROLE_BIT = 7;
    localparam int GTMSS_TABLE_BITS = 128;
    // Role encoding: 0 drives the control table, 1 shows the status table
    localparam logic GTMSS_ROLE_CONTROL = 1'b0;
    localparam logic GTMSS_ROLE_STATUS = 1'b1;
    // Reconfiguration time after a spur-setting change
    localparam longint unsigned GTMSS_RECONF_TIME_MS = 64'd200;
    localparam longint unsigned GTMSS_CLK_HZ = 64'd200_000_000;
    localparam longint unsigned GTMSS_RECONF_CYCLES =
        (GTMSS_RECONF_TIME_MS * GTMSS_CLK_HZ) / 64'd1000;
    // Reconfiguration state
    typedef enum logic [0:0] {GTMSS_ST_IDLE, GTMSS_ST_RECONF} gtmss_state_t;
endpackage

// file: hdl/gtmss_pin_slot.sv
// One general-purpose pin: table index decode, role select and pin driving
`timescale 1ns/1ps
module gtmss_pin_slot
    import gtmss_pkg::*;
#(
    parameter int TABLE_BITS = GTMSS_TABLE_BITS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] func_i,
    input wire logic pin_i,
    input wire logic [TABLE_BITS-1:0] status_table_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic [TABLE_BITS-1:0] ctrl_mask_o,
    output logic [TABLE_BITS-1:0] ctrl_val_o
);
    logic [1:0] pin_sync_r;
    logic [1:0] pin_sync_nxt;
    logic pin_o_r;
    logic pin_o_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;
    logic [TABLE_BITS-1:0] mask_r;
    logic [TABLE_BITS-1:0] mask_nxt;
    logic [TABLE_BITS-1:0] val_r;
    logic [TABLE_BITS-1:0] val_nxt;
    logic [GTMSS_IDX_MSB:GTMSS_IDX_LSB] idx;
    logic role;

    assign idx = func_i[GTMSS_IDX_MSB:GTMSS_IDX_LSB];
    assign role = func_i[GTMSS_ROLE_BIT];

    // Next values: sync the pin, pick the table bit, steer by role
    always_comb begin
        pin_sync_nxt = {pin_sync_r[0], pin_i};
        mask_nxt = '0;
        val_nxt = '0;
        pin_o_nxt = 1'b0;
        pin_oe_nxt = 1'b0;
        if (role == GTMSS_ROLE_CONTROL) begin
            mask_nxt[idx] = 1'b1;
            val_nxt[idx] = pin_sync_r[1];
        end else begin
            pin_o_nxt = status_table_i[idx];
            pin_oe_nxt = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync_r <= '0;
            mask_r <= '0;
            val_r <= '0;
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            pin_sync_r <= pin_sync_nxt;
            mask_r <= mask_nxt;
            val_r <= val_nxt;
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign pin_o = pin_o_r;
    assign pin_oe_o = pin_oe_r;
    assign ctrl_mask_o = mask_r;
    assign ctrl_val_o = val_r;
endmodule

// file: hdl/gtmss_top.sv
// Pin-to-table mapping for two general pins and the spur-reduction setting
// What this block does
// - Each pin's function bits 6:0 index one bit of a 128-bit table.
// - Function bit 7: 0 makes pin drive control bit, 1 shows status bit.
// - Both pin function registers reset to zero, so both pins drive control bit 0.
// - A spur-setting change starts 200 ms reconfiguration; host stays off meanwhile.
`timescale 1ns/1ps
module gtmss_top
    import gtmss_pkg::*;
#(
    parameter int TABLE_BITS = GTMSS_TABLE_BITS,
    parameter int RECONF_CYCLES = int'(GTMSS_RECONF_CYCLES)
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    output logic BUSY_O,
    output logic [7:0] SPUR_SETTING_O,
    input wire logic GENERAL_PIN_FIVE_I,
    output logic GENERAL_PIN_FIVE_O,
    output logic GENERAL_PIN_FIVE_OE_O,
    input wire logic GENERAL_PIN_SIX_I,
    output logic GENERAL_PIN_SIX_O,
    output logic GENERAL_PIN_SIX_OE_O,
    input wire logic [TABLE_BITS-1:0] STATUS_TABLE_I,
    output logic [TABLE_BITS-1:0] CONTROL_MASK_O,
    output logic [TABLE_BITS-1:0] CONTROL_TABLE_O
);
    localparam int NPINS = 2;
    localparam int CW = $clog2(RECONF_CYCLES + 1);

    // Reset release synchroniser
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Register file and reconfiguration state
    logic [7:0] pin5_function_select_r;
    logic [7:0] pin5_function_select_nxt;
    logic [7:0] pin6_function_select_r;
    logic [7:0] pin6_function_select_nxt;
    logic [7:0] spur_reduction_setting_r;
    logic [7:0] spur_reduction_setting_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    gtmss_state_t state_r;
    gtmss_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic busy;

    assign busy = (state_r == GTMSS_ST_RECONF);

    // Register writes and reconfiguration timer
    always_comb begin
        pin5_function_select_nxt = pin5_function_select_r;
        pin6_function_select_nxt = pin6_function_select_r;
        spur_reduction_setting_nxt = spur_reduction_setting_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            GTMSS_ST_IDLE: begin
                if (REG_WR_I) begin
                    if (REG_ADDR_I == GTMSS_OFS_PIN5_FUNC) begin
                        pin5_function_select_nxt = REG_WDATA_I;
                    end else if (REG_ADDR_I == GTMSS_OFS_PIN6_FUNC) begin
                        pin6_function_select_nxt = REG_WDATA_I;
                    end else if (REG_ADDR_I == GTMSS_OFS_SPUR) begin
                        spur_reduction_setting_nxt = REG_WDATA_I;
                        if (REG_WDATA_I != spur_reduction_setting_r) begin
                            state_nxt = GTMSS_ST_RECONF;
                            cnt_nxt = CW'(RECONF_CYCLES - 1);
                        end
                    end
                end
            end
            GTMSS_ST_RECONF: begin
                // Writes are dropped so nothing is disturbed while busy
                if (cnt_r == '0) begin
                    state_nxt = GTMSS_ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            default: begin
                state_nxt = GTMSS_ST_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pin5_function_select_r <= GTMSS_RST_PIN_FUNC;
            pin6_function_select_r <= GTMSS_RST_PIN_FUNC;
            spur_reduction_setting_r <= GTMSS_RST_SPUR;
            state_r <= GTMSS_ST_IDLE;
            cnt_r <= '0;
        end else begin
            pin5_function_select_r <= pin5_function_select_nxt;
            pin6_function_select_r <= pin6_function_select_nxt;
            spur_reduction_setting_r <= spur_reduction_setting_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Read answers: zero while reconfiguring and for unmapped places
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (REG_RD_I && !REG_WR_I) begin
            rvalid_nxt = 1'b1;
            if (busy) begin
                rdata_nxt = 8'h00;
            end else if (REG_ADDR_I == GTMSS_OFS_PIN5_FUNC) begin
                rdata_nxt = pin5_function_select_r;
            end else if (REG_ADDR_I == GTMSS_OFS_PIN6_FUNC) begin
                rdata_nxt = pin6_function_select_r;
            end else if (REG_ADDR_I == GTMSS_OFS_SPUR) begin
                rdata_nxt = spur_reduction_setting_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Read answer registers
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Per-pin mapping slots
    logic [7:0] func [NPINS];
    logic pin_in [NPINS];
    logic pin_out [NPINS];
    logic pin_oe [NPINS];
    logic [TABLE_BITS-1:0] mask [NPINS];
    logic [TABLE_BITS-1:0] val [NPINS];

    assign func[0] = pin5_function_select_r;
    assign func[1] = pin6_function_select_r;
    assign pin_in[0] = GENERAL_PIN_FIVE_I;
    assign pin_in[1] = GENERAL_PIN_SIX_I;

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            gtmss_pin_slot #(
                .TABLE_BITS(TABLE_BITS)
            ) u_slot (
                .clk_i(REF_CLK_I),
                .rst_n_i(rst_n),
                .func_i(func[g]),
                .pin_i(pin_in[g]),
                .status_table_i(STATUS_TABLE_I),
                .pin_o(pin_out[g]),
                .pin_oe_o(pin_oe[g]),
                .ctrl_mask_o(mask[g]),
                .ctrl_val_o(val[g])
            );
        end
    endgenerate

    // Merged control-table contributions of all pins
    logic [TABLE_BITS-1:0] ctrl_mask_r;
    logic [TABLE_BITS-1:0] ctrl_mask_nxt;
    logic [TABLE_BITS-1:0] ctrl_val_r;
    logic [TABLE_BITS-1:0] ctrl_val_nxt;

    // Pins claiming one bit are ORed together
    always_comb begin
        ctrl_mask_nxt = '0;
        ctrl_val_nxt = '0;
        for (int p = 0; p < NPINS; p++) begin
            ctrl_mask_nxt = ctrl_mask_nxt | mask[p];
            ctrl_val_nxt = ctrl_val_nxt | val[p];
        end
    end

    // Output flops so the table outputs never glitch
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_mask_r <= '0;
            ctrl_val_r <= '0;
        end else begin
            ctrl_mask_r <= ctrl_mask_nxt;
            ctrl_val_r <= ctrl_val_nxt;
        end
    end

    assign CONTROL_MASK_O = ctrl_mask_r;
    assign CONTROL_TABLE_O = ctrl_val_r;

    assign GENERAL_PIN_FIVE_O = pin_out[0];
    assign GENERAL_PIN_FIVE_OE_O = pin_oe[0];
    assign GENERAL_PIN_SIX_O = pin_out[1];
    assign GENERAL_PIN_SIX_OE_O = pin_oe[1];
    assign REG_RDATA_O = rdata_r;
    assign REG_RVALID_O = rvalid_r;
    assign BUSY_O = busy;
    assign SPUR_SETTING_O = spur_reduction_setting_r;
endmodule

// file: tb/gtmss_properties.sv
// Port assertions for the pin-mapping and spur-setting block
`timescale 1ns/1ps
module gtmss_properties #(
    parameter int TABLE_BITS = 128,
    parameter int RECONF_CYCLES = 20
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic REG_RVALID_O,
    input wire logic BUSY_O,
    input wire logic [7:0] SPUR_SETTING_O,
    input wire logic GENERAL_PIN_FIVE_O,
    input wire logic GENERAL_PIN_FIVE_OE_O,
    input wire logic [TABLE_BITS-1:0] STATUS_TABLE_I,
    input wire logic [TABLE_BITS-1:0] CONTROL_MASK_O
);
    logic [7:0] f5_r;
    logic [3:0] up_r;
    int cnt_r;
    // Pin five register mirror, settle delay after reset, busy cycle count
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            f5_r <= 8'h00;
            up_r <= 4'h0;
            cnt_r <= 0;
        end else begin
            if (REG_WR_I && !BUSY_O && REG_ADDR_I == 8'hE5) f5_r <= REG_WDATA_I;
            up_r <= {up_r[2:0], 1'b1};
            cnt_r <= BUSY_O ? cnt_r + 1 : 0;
        end
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    chk_reset_idle: assert property (
        $rose(RESET_N_I) |-> !GENERAL_PIN_FIVE_OE_O && !BUSY_O) else $error("not idle at reset");
    chk_role_oe: assert property (
        $stable(f5_r) |-> GENERAL_PIN_FIVE_OE_O == f5_r[7]) else $error("enable ignores role");
    chk_status_pin: assert property (
        f5_r[7] && $stable(f5_r) |-> GENERAL_PIN_FIVE_O == $past(STATUS_TABLE_I[f5_r[6:0]]))
        else $error("pin shows wrong status bit");
    chk_ctrl_mask: assert property (
        up_r[3] && !f5_r[7] && $stable(f5_r) && $past(f5_r, 2) == f5_r
        |-> CONTROL_MASK_O[f5_r[6:0]])
        else $error("control bit not claimed");
    chk_busy_start: assert property (
        REG_WR_I && !BUSY_O && REG_ADDR_I == 8'hF7 && REG_WDATA_I != SPUR_SETTING_O
        |=> BUSY_O && SPUR_SETTING_O == $past(REG_WDATA_I)) else $error("no busy on change");
    chk_busy_len: assert property (
        $fell(BUSY_O) |-> cnt_r == RECONF_CYCLES) else $error("busy too short");
    chk_busy_max: assert property (
        BUSY_O |-> cnt_r < RECONF_CYCLES) else $error("busy too long");
    chk_busy_hold: assert property (
        BUSY_O |=> $stable(SPUR_SETTING_O)) else $error("setting moved while busy");
    chk_busy_read: assert property (
        BUSY_O && REG_RD_I && !REG_WR_I |=> REG_RVALID_O && REG_RDATA_O == 8'h00)
        else $error("busy read not zero");
    cover property ($rose(BUSY_O));
    cover property (GENERAL_PIN_FIVE_OE_O && GENERAL_PIN_FIVE_O);
    cover property (REG_RVALID_O && REG_RDATA_O != 8'h00);
endmodule
bind gtmss_top gtmss_properties #(.TABLE_BITS(TABLE_BITS), .RECONF_CYCLES(RECONF_CYCLES)) chk_i (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .BUSY_O(BUSY_O),
    .SPUR_SETTING_O(SPUR_SETTING_O), .GENERAL_PIN_FIVE_O(GENERAL_PIN_FIVE_O),
    .GENERAL_PIN_FIVE_OE_O(GENERAL_PIN_FIVE_OE_O), .STATUS_TABLE_I(STATUS_TABLE_I),
    .CONTROL_MASK_O(CONTROL_MASK_O));

// file: tb/gtmss_host.sv
// Host model on the register port of the block
`timescale 1ns/1ps
module gtmss_host (
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic rvalid_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic hung_o = 1'b0
);
    // One access; with idle set it first waits up to 64 cycles for busy to fall, then sets hung_o if still busy
    task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d, input bit idle,
                       output logic [7:0] q, output logic v);
        int n;
        n = 0;
        @(posedge clk_i);
        while (idle && busy_i && n < 64) begin
            @(posedge clk_i);
            n++;
        end
        hung_o <= idle & busy_i;
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        q = rdata_i;
        v = rvalid_i;
    endtask
endmodule

// file: tb/gtmss_bench.sv
// Self-checking bench for the pin-mapping and spur-setting block
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module gtmss_bench;
    import gtmss_pkg::*;
    typedef struct {bit w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} gtmss_row_t;
    logic [127:0] stat = 128'h20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic p5 = 1'b1;
    logic p6 = 1'b0;
    logic [7:0] addr, wdata, rdata, spur, q;
    logic wr, rd, rvalid, busy, hung, v;
    logic [1:0] pin_o, pin_oe;
    logic [127:0] cmask, ctab;
    int failures = 0;
    int cmp_count = 0;
    int k;
    // Reset reads, then writes to both pins, both roles, index ends, unmapped place
    gtmss_row_t rows[10] = '{'{0, 8'hE5, 8'h00, 8'h00}, '{0, 8'hE6, 8'h00, 8'h00},
        '{0, 8'hF7, 8'h00, 8'h00}, '{1, 8'hE5, 8'h85, 8'h85}, '{1, 8'hE6, 8'h7F, 8'h7F},
        '{1, 8'hE5, 8'hFF, 8'hFF}, '{1, 8'hE6, 8'h00, 8'h00}, '{1, 8'hE5, 8'h40, 8'h40},
        '{1, 8'hF0, 8'h5A, 8'h00}, '{1, 8'hE6, 8'h85, 8'h85}};
    always #2.5 clk = ~clk;
    gtmss_top #(.RECONF_CYCLES(20)) gtmss_top_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .BUSY_O(busy), .SPUR_SETTING_O(spur),
        .GENERAL_PIN_FIVE_I(p5), .GENERAL_PIN_FIVE_O(pin_o[0]), .GENERAL_PIN_FIVE_OE_O(pin_oe[0]),
        .GENERAL_PIN_SIX_I(p6), .GENERAL_PIN_SIX_O(pin_o[1]), .GENERAL_PIN_SIX_OE_O(pin_oe[1]),
        .STATUS_TABLE_I(stat), .CONTROL_MASK_O(cmask), .CONTROL_TABLE_O(ctab));
    gtmss_host gtmss_host_inst (.clk_i(clk), .busy_i(busy), .rvalid_i(rvalid), .rdata_i(rdata),
        .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .hung_o(hung));
    // Verdict and end of run
    task automatic wrap_up;
        $display("checks %0d errors %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog for hangs and a host stuck behind busy
    initial begin
        for (int t = 0; t < 5000 && !hung; t++) @(posedge clk);
        failures++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            if (rows[i].w) gtmss_host_inst.acc(1'b1, rows[i].a, rows[i].d, 1'b1, q, v);
            gtmss_host_inst.acc(1'b0, rows[i].a, 8'h00, 1'b1, q, v);
            `CHK("readback", rows[i].e, q)
            `CHK("read valid", 1'b1, v)
            repeat (3) @(posedge clk);
            #1 k = rows[i].a[1];
            if (rows[i].w && rows[i].e[7]) begin
                `CHK("pin enable", 1'b1, pin_oe[k])
                `CHK("pin value", stat[rows[i].e[6:0]], pin_o[k])
            end else if (rows[i].w && rows[i].a != 8'hF0) begin
                `CHK("pin enable", 1'b0, pin_oe[k])
                `CHK("ctrl mask", 1'b1, cmask[rows[i].e[6:0]])
                `CHK("ctrl value", k ? p6 : p5, ctab[rows[i].e[6:0]])
            end
        end
        // Pin input and status table changes reach the mapped bits
        @(posedge clk);
        p5 <= 1'b0;
        stat <= '0;
        repeat (5) @(posedge clk);
        #1;
        `CHK("ctrl follows pin", p5, ctab[64])
        `CHK("status follows table", stat[5], pin_o[1])
        // Spur change, then a read and a write while busy
        gtmss_host_inst.acc(1'b1, GTMSS_OFS_SPUR, 8'h3C, 1'b1, q, v);
        `CHK("busy", 1'b1, busy)
        gtmss_host_inst.acc(1'b0, GTMSS_OFS_PIN5_FUNC, 8'h00, 1'b0, q, v);
        `CHK("busy read", 9'h100, {v, q})
        gtmss_host_inst.acc(1'b1, GTMSS_OFS_PIN5_FUNC, 8'h11, 1'b0, q, v);
        gtmss_host_inst.acc(1'b0, GTMSS_OFS_PIN5_FUNC, 8'h00, 1'b1, q, v);
        `CHK("kept func", 8'h40, q)
        // Same value again must not start a reconfiguration
        gtmss_host_inst.acc(1'b1, GTMSS_OFS_SPUR, 8'h3C, 1'b1, q, v);
        `CHK("no busy", 1'b0, busy)
        `CHK("spur", 8'h3C, spur)
        // Reset in mid-run clears the function registers
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        gtmss_host_inst.acc(1'b0, GTMSS_OFS_PIN5_FUNC, 8'h00, 1'b1, q, v);
        `CHK("func after reset", 8'h00, q)
        `CHK("spur after reset", 8'h00, spur)
        wrap_up();
    end
endmodule
